// [verilog/fcd_consts.svh]
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH
`define FCD_NUM_DECADES 5
`define FCD_DECADE_MAX 4'h9
`define FCD_OVF_RISE_CNT 4'h8
`define FCD_CLK_HZ 40000000
`define FCD_CYCLES_PER_SEC 5
`define FCD_IDLE_CYCLES (`FCD_CLK_HZ / `FCD_CYCLES_PER_SEC)
`define FCD_DP_SECOND 2'h0
`define FCD_DP_THIRD 2'h1
`define FCD_DP_FOURTH 2'h2
`endif

// [verilog/fcd_pkg.sv]
package fcd_pkg;
   typedef enum logic [1:0] {
      FCD_ST_COUNT = 2'b00,
      FCD_ST_IDLE = 2'b01
   } fcd_state_t;
   typedef struct packed {
      logic reset_pulse;
      logic transfer_pulse;
      logic gate_open;
   } fcd_ctrl_t;
   typedef struct packed {
      logic [9:0] numeral_n;
   } fcd_digit_t;
endpackage

// [verilog/fcd_decade.sv]
`timescale 1ns/100ps
`include "fcd_consts.svh"
module fcd_decade (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Control
   input wire logic i_clear,
   input wire logic i_transfer,
   input wire logic i_pulse,
   // Outputs
   output logic o_carry,
   output logic [3:0] o_latched
);
   logic [3:0] count_q;
   logic [3:0] latch_q;
   logic wrap;
   assign wrap = i_pulse && (count_q == `FCD_DECADE_MAX);
   assign o_carry = wrap;
   assign o_latched = latch_q;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_q <= 4'h0;
      end else if (i_ce) begin
         if (i_clear) begin
            count_q <= 4'h0;
         end else if (i_pulse) begin
            count_q <= wrap ? 4'h0 : count_q + 4'h1;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_q <= 4'h0;
      end else if (i_ce && i_transfer) begin
         latch_q <= count_q;
      end
   end

   carry_once_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_carry |-> count_q == 4'h9) else $error("carry without nine");
   hold_value_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !i_clear && !i_pulse) |=> $stable(count_q))
      else $error("decade moved while idle");
endmodule

// [verilog/fcd_decoder.sv]
`timescale 1ns/100ps
module fcd_decoder (
   // Latched digit
   input wire logic [3:0] i_bcd,
   // Numeral drive
   output fcd_pkg::fcd_digit_t o_digit
);
   import fcd_pkg::*;
   function automatic logic [9:0] one_of_ten(input logic [3:0] v);
      logic [9:0] r;
      r = 10'h3FF;
      if (v <= 4'h9) begin
         r[v] = 1'b0;
      end
      return r;
   endfunction
   assign o_digit.numeral_n = one_of_ten(i_bcd);
   one_low_a: assert property (@(i_bcd)
      (i_bcd > 4'h9) || $onehot(~o_digit.numeral_n))
      else $error("decoder not one-of-ten");
endmodule

// [verilog/fcd_top.sv]
`timescale 1ns/100ps
`include "fcd_consts.svh"
module fcd_top #(
   parameter int NUM_DECADES = `FCD_NUM_DECADES,
   parameter int IDLE_CYCLES = `FCD_IDLE_CYCLES
) (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_ce,
   // Mode and signal
   input wire logic i_counter_mode,
   input wire logic i_signal_pulse,
   // Far-side control
   input fcd_pkg::fcd_ctrl_t i_ctrl,
   input wire logic [1:0] i_dp_select,
   // Sample-rate flag and count initiate
   output logic o_sample_rate_q,
   output logic o_count_initiate,
   // Displays
   output fcd_pkg::fcd_digit_t o_lower_digit_displays [NUM_DECADES],
   output logic o_numeral_one_switch,
   output logic o_second_digit_display_dp,
   output logic o_third_digit_display_dp,
   output logic o_fourth_digit_display_dp
);
   import fcd_pkg::*;

   // Refuse sizes the logic cannot serve
   if (NUM_DECADES < 1 || NUM_DECADES > 8) begin : g_bad_decades
      $error("NUM_DECADES out of range");
   end
   if (IDLE_CYCLES < 2) begin : g_bad_idle
      $error("IDLE_CYCLES too small");
   end

   // Decimal point select decode
   function automatic logic dp_hit(input logic [1:0] sel, input logic [1:0] code);
      return sel == code;
   endfunction

   // Count initiator
   fcd_state_t state_q;
   logic [31:0] idle_cnt_q;
   logic idle_done;
   assign idle_done = (idle_cnt_q == 32'(IDLE_CYCLES - 1));

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= FCD_ST_COUNT;
      end else if (i_ce) begin
         unique case (state_q)
            FCD_ST_COUNT: begin
               if (i_ctrl.transfer_pulse) begin
                  state_q <= FCD_ST_IDLE;
               end
            end
            FCD_ST_IDLE: begin
               if (idle_done && i_counter_mode) begin
                  state_q <= FCD_ST_COUNT;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         idle_cnt_q <= 32'h0;
      end else if (i_ce) begin
         if (state_q == FCD_ST_IDLE && i_counter_mode && !idle_done) begin
            idle_cnt_q <= idle_cnt_q + 32'h1;
         end else begin
            idle_cnt_q <= 32'h0;
         end
      end
   end

   assign o_sample_rate_q = (state_q == FCD_ST_IDLE);
   assign o_count_initiate = (state_q == FCD_ST_IDLE) && idle_done && i_counter_mode && i_ce;

   // Decade chain
   logic gated_pulse;
   logic [NUM_DECADES:0] carry;
   assign gated_pulse = i_signal_pulse && i_ctrl.gate_open;
   assign carry[0] = gated_pulse;

   genvar g;
   generate
      for (g = 0; g < NUM_DECADES; g++) begin : g_dec
         logic [3:0] bcd;
         fcd_decade u_decade (
            .i_mclk(i_mclk),
            .i_sys_rst(i_sys_rst),
            .i_ce(i_ce),
            .i_clear(i_ctrl.reset_pulse),
            .i_transfer(i_ctrl.transfer_pulse),
            .i_pulse(carry[g]),
            .o_carry(carry[g+1]),
            .o_latched(bcd)
         );
         fcd_decoder u_decoder (
            .i_bcd(bcd),
            .o_digit(o_lower_digit_displays[g])
         );
         bcd_range_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
            bcd <= `FCD_DECADE_MAX) else $error("latched digit out of range");
         chain_order_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
            carry[g+1] |-> carry[g]) else $error("carry without input pulse");
      end
   endgenerate

   // Overflow stage, fed by the last decade carry
   logic [3:0] ovf_cnt_q;
   logic ovf_out;
   logic ovf_out_prev_q;
   logic ovf_flop_q;
   logic ovf_latch_q;
   logic ovf_fall;
   assign ovf_out = (ovf_cnt_q >= `FCD_OVF_RISE_CNT);
   assign ovf_fall = ovf_out_prev_q && !ovf_out;

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ovf_cnt_q <= 4'h0;
      end else if (i_ce) begin
         if (i_ctrl.reset_pulse) begin
            ovf_cnt_q <= 4'h0;
         end else if (carry[NUM_DECADES]) begin
            ovf_cnt_q <= (ovf_cnt_q == `FCD_DECADE_MAX) ? 4'h0 : ovf_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ovf_out_prev_q <= 1'b0;
      end else if (i_ce) begin
         ovf_out_prev_q <= i_ctrl.reset_pulse ? 1'b0 : ovf_out;
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ovf_flop_q <= 1'b0;
      end else if (i_ce) begin
         if (i_ctrl.reset_pulse) begin
            ovf_flop_q <= 1'b0;
         end else if (ovf_fall) begin
            ovf_flop_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ovf_latch_q <= 1'b0;
      end else if (i_ce) begin
         if (i_ctrl.reset_pulse) begin
            ovf_latch_q <= 1'b0;
         end else if (ovf_flop_q) begin
            ovf_latch_q <= 1'b1;
         end
      end
   end

   assign o_numeral_one_switch = ovf_latch_q;

   // Decimal points
   always_ff @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_second_digit_display_dp <= 1'b0;
         o_third_digit_display_dp <= 1'b0;
         o_fourth_digit_display_dp <= 1'b0;
      end else if (i_ce) begin
         o_second_digit_display_dp <= dp_hit(i_dp_select, `FCD_DP_SECOND);
         o_third_digit_display_dp <= dp_hit(i_dp_select, `FCD_DP_THIRD);
         o_fourth_digit_display_dp <= dp_hit(i_dp_select, `FCD_DP_FOURTH);
      end
   end

   // Checks
   gate_blocks_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_ctrl.gate_open |-> !carry[0]) else $error("pulse passed closed gate");
   rise_no_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !i_ctrl.reset_pulse && !ovf_flop_q && !ovf_fall) |=> !ovf_flop_q)
      else $error("overflow set without fall");
   fall_sets_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && ovf_fall && !i_ctrl.reset_pulse) |=> ovf_flop_q)
      else $error("fall did not set overflow");
   latch_follows_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && ovf_flop_q && !i_ctrl.reset_pulse) |=> o_numeral_one_switch)
      else $error("latch did not follow");
   reset_clears_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && i_ctrl.reset_pulse) |=> !ovf_flop_q && !ovf_latch_q)
      else $error("reset missed overflow");
   transfer_keeps_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && i_ctrl.transfer_pulse && !i_ctrl.reset_pulse && ovf_latch_q) |=> ovf_latch_q)
      else $error("transfer touched overflow");
   blank_low_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_numeral_one_switch |-> $past(ovf_flop_q)) else $error("one lit early");
   dp_one_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $onehot0({o_second_digit_display_dp, o_third_digit_display_dp,
         o_fourth_digit_display_dp})) else $error("two decimal points");
   idle_restart_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && o_count_initiate) |=> !o_sample_rate_q)
      else $error("initiate did not clear flag");
   idle_bound_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      idle_cnt_q <= 32'(IDLE_CYCLES - 1)) else $error("idle count overran");

   // Initiator checks
   idle_enter_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !o_sample_rate_q && i_ctrl.transfer_pulse) |=> o_sample_rate_q)
      else $error("transfer did not start idle");
   idle_wait_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && o_sample_rate_q && !o_count_initiate) |=> o_sample_rate_q)
      else $error("idle left early");

   count_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (state_q == FCD_ST_COUNT) |-> idle_cnt_q == 32'h0)
      else $error("idle count live while counting");
   sr_initiate_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_count_initiate |-> o_sample_rate_q)
      else $error("initiate outside idle");

   manual_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !i_counter_mode) |=> idle_cnt_q == 32'h0)
      else $error("idle delay ran outside counter mode");
   manual_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_counter_mode |-> !o_count_initiate)
      else $error("initiate outside counter mode");

   initiate_pulse_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_count_initiate |=> !o_count_initiate)
      else $error("initiate longer than one cycle");
   idle_step_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && o_sample_rate_q && i_counter_mode && !idle_done) |=>
      idle_cnt_q == $past(idle_cnt_q) + 32'h1) else $error("idle delay stalled");

   // Chain entry checks
   entry_gate_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      gated_pulse |-> i_signal_pulse) else $error("pulse invented at gate");
   chain_feed_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      carry[NUM_DECADES] |-> gated_pulse)
      else $error("overflow fed without input");

   // Overflow checks
   ovf_range_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      ovf_cnt_q <= `FCD_DECADE_MAX) else $error("overflow counter out of range");
   ovf_rise_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(ovf_out) |-> ovf_cnt_q == `FCD_OVF_RISE_CNT)
      else $error("overflow output rose off eight");

   ovf_wrap_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !i_ctrl.reset_pulse && carry[NUM_DECADES] && ovf_cnt_q == `FCD_DECADE_MAX)
      |=> ovf_cnt_q == 4'h0 && ovf_fall) else $error("tenth carry missed fall");
   ovf_quiet_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && !i_ctrl.reset_pulse && !carry[NUM_DECADES]) |=> $stable(ovf_cnt_q))
      else $error("overflow counter moved alone");

   flop_source_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(ovf_flop_q) |-> $past(ovf_fall)) else $error("overflow set off fall");
   latch_source_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(ovf_latch_q) |-> $past(ovf_flop_q))
      else $error("overflow latch set alone");

   flop_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && ovf_flop_q && !i_ctrl.reset_pulse) |=> ovf_flop_q)
      else $error("overflow flop dropped");
   latch_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && ovf_latch_q && !i_ctrl.reset_pulse) |=> ovf_latch_q)
      else $error("overflow latch dropped");

   reset_fall_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && i_ctrl.reset_pulse) |=> !ovf_fall && ovf_cnt_q == 4'h0)
      else $error("reset left overflow stage live");
   reset_blank_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && i_ctrl.reset_pulse) |=> !o_numeral_one_switch)
      else $error("leading digit lit after reset");

   // Enable and decimal point checks
   ce_freeze_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      !i_ce |=> $stable(state_q) && $stable(idle_cnt_q) && $stable(ovf_cnt_q) &&
      $stable(ovf_out_prev_q) && $stable(ovf_flop_q) && $stable(ovf_latch_q) &&
      $stable(o_second_digit_display_dp)) else $error("state moved while frozen");
   dp_follow_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      i_ce |=> {o_second_digit_display_dp, o_third_digit_display_dp, o_fourth_digit_display_dp}
      == $past({dp_hit(i_dp_select, `FCD_DP_SECOND), dp_hit(i_dp_select, `FCD_DP_THIRD),
      dp_hit(i_dp_select, `FCD_DP_FOURTH)})) else $error("decimal point wrong");
   dp_none_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
      (i_ce && i_dp_select == 2'h3) |=> !o_second_digit_display_dp &&
      !o_third_digit_display_dp && !o_fourth_digit_display_dp)
      else $error("decimal point without select");

   cov_initiate_c: cover property (@(posedge i_mclk) disable iff (i_sys_rst) o_count_initiate);
   cov_overflow_c: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_numeral_one_switch));
   cov_chain_c: cover property (@(posedge i_mclk) disable iff (i_sys_rst) carry[NUM_DECADES]);
   cov_dp_c: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      o_fourth_digit_display_dp);
   cov_restart_c: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
      $fell(o_sample_rate_q));
endmodule

// [bench/fcd_far_side.sv]
`timescale 1ns/100ps
module fcd_far_side (
   // Clock
   input wire logic i_mclk,
   // Requests
   input wire logic i_start,
   input wire logic i_xfer_only,
   input wire logic i_initiate,
   input wire logic [15:0] i_gate_len,
   // Control to block
   output fcd_pkg::fcd_ctrl_t o_ctrl,
   output logic o_busy
);
   import fcd_pkg::*;
   initial begin
      o_ctrl = '0;
      o_busy = 1'b0;
      forever begin
         @(negedge i_mclk);
         if (i_start || i_initiate || i_xfer_only) begin
            o_busy = 1'b1;
            if (!i_xfer_only) begin
               o_ctrl.reset_pulse = 1'b1;
               @(negedge i_mclk);
               o_ctrl.reset_pulse = 1'b0;
               o_ctrl.gate_open = 1'b1;
               repeat (i_gate_len) @(negedge i_mclk);
               o_ctrl.gate_open = 1'b0;
               @(negedge i_mclk);
            end
            o_ctrl.transfer_pulse = 1'b1;
            @(negedge i_mclk);
            o_ctrl.transfer_pulse = 1'b0;
            o_busy = 1'b0;
         end
      end
   end
endmodule

// [bench/frequency_counter_display_chain_test.sv]
`timescale 1ns/100ps
module frequency_counter_display_chain_test;
   import fcd_pkg::*;
   localparam int ND = 2;
   localparam int IDLE = 20;
   localparam int OVF_PT = 10 * (10 ** ND);
   logic i_mclk, i_sys_rst, i_ce, mode, sig, start, xfer_only, busy, dense;
   logic [1:0] dp_sel;
   logic [15:0] gate_len;
   fcd_ctrl_t ctrl;
   fcd_digit_t digs [ND];
   logic sr, init, sw, dp2, dp3, dp4;
   int err_count, cmp_count, cnt, lat, ovf, k;

   fcd_top #(.NUM_DECADES(ND), .IDLE_CYCLES(IDLE)) fcd_top_inst (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_counter_mode(mode),
      .i_signal_pulse(sig), .i_ctrl(ctrl), .i_dp_select(dp_sel), .o_sample_rate_q(sr),
      .o_count_initiate(init), .o_lower_digit_displays(digs), .o_numeral_one_switch(sw),
      .o_second_digit_display_dp(dp2), .o_third_digit_display_dp(dp3),
      .o_fourth_digit_display_dp(dp4));
   fcd_far_side fcd_far_side_inst (.i_mclk(i_mclk), .i_start(start), .i_xfer_only(xfer_only),
      .i_initiate(init), .i_gate_len(gate_len), .o_ctrl(ctrl), .o_busy(busy));

   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end

   // Reference count, overflow and latch
   always @(posedge i_mclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt = 0;
         ovf = 0;
         lat = 0;
      end else if (i_ce) begin
         if (ctrl.reset_pulse) begin
            cnt = 0;
            ovf = 0;
         end else if (ctrl.gate_open && sig) begin
            cnt++;
         end
         if (cnt >= OVF_PT) ovf = 1;
         if (ctrl.transfer_pulse) lat = cnt;
      end
   end

   always @(negedge i_mclk) sig <= dense | ($urandom % 2 == 1);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic finish_count();
      int j;
      for (j = 0; j < 20 && !busy; j++) @(posedge i_mclk);
      @(negedge i_mclk);
      start = 1'b0;
      xfer_only = 1'b0;
      for (j = 0; j < 5000 && busy; j++) @(posedge i_mclk);
      repeat (2) @(negedge i_mclk);
      for (j = 0; j < ND; j++) begin
         check({22'h0, digs[j]}, {22'h0, ~(10'h1 << ((lat / (10 ** j)) % 10))});
      end
      check({31'h0, sw}, ovf);
   endtask

   task automatic run_count(input int len, input logic dn, input logic xo);
      dense = dn;
      gate_len = len[15:0];
      if (xo) xfer_only = 1'b1;
      else start = 1'b1;
      finish_count();
   endtask

   initial begin
      #(25 * 30000);
      err_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      void'($urandom(93064));
      {i_ce, mode, start, xfer_only, dense, sig} = 6'h20;
      dp_sel = 2'h3;
      gate_len = 16'h10;
      err_count = 0;
      cmp_count = 0;
      i_sys_rst = 1'b1;
      repeat (8) @(posedge i_mclk);
      @(negedge i_mclk);
      i_sys_rst = 1'b0;
      for (k = 0; k < ND; k++) check({22'h0, digs[k]}, 32'h3FE);
      check({30'h0, sw, sr}, 32'h0);
      run_count(7, 1'b0, 1'b0);
      run_count(800, 1'b1, 1'b0);
      run_count(1000, 1'b1, 1'b0);
      run_count(0, 1'b0, 1'b1);
      run_count(53, 1'b0, 1'b0);
      for (k = 0; k < 3; k++) run_count(1 + $urandom % 300, 1'b0, 1'b0);
      for (k = 0; k < 4; k++) begin
         dp_sel = k[1:0];
         repeat (2) @(negedge i_mclk);
         check({29'h0, dp2, dp3, dp4}, {29'h0, k == 0, k == 1, k == 2});
      end
      // Clock enable low freezes the decimal points
      i_ce = 1'b0;
      dp_sel = 2'h0;
      repeat (3) @(negedge i_mclk);
      check({31'h0, dp2}, 32'h0);
      i_ce = 1'b1;
      repeat (2) @(negedge i_mclk);
      check({31'h0, dp2}, 32'h1);
      dp_sel = 2'h3;
      // Self-started cycles
      mode = 1'b1;
      run_count(30, 1'b0, 1'b0);
      check({31'h0, sr}, 32'h1);
      for (k = 0; k < 100 && !init; k++) @(negedge i_mclk);
      check({31'h0, (k >= IDLE - 3 && k <= IDLE + 1)}, 32'h1);
      @(negedge i_mclk);
      check({31'h0, sr}, 32'h0);
      finish_count();
      mode = 1'b0;
      complete_run();
   end
endmodule
